// ===== bench/ssld_ctl_model.sv
// ----------------------------------------------------------------
// controller model driving the serial lines
// ----------------------------------------------------------------
module ssld_ctl_model (
  // system clock, used only as a time base
  input wire logic clk,
  // serial lines toward the driver
  output logic ser_clk,
  output logic ser_din,
  output logic ser_load
);
  timeunit 1ns;
  timeprecision 1ps;
  // half of the 160 ns link period, in system clock cycles
  localparam int HALF = 10;
  // lines start quiet with the link clock low
  initial begin
    ser_clk = 1'h0;
    ser_din = 1'h0;
    ser_load = 1'h0;
  end
  // move just after a system clock edge, as the pins of a real controller would
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // data set up, then clock raised; clock idles low
  task automatic rise_bit(input logic b);
    ser_din = b;
    wait_cyc(HALF / 2);
    ser_clk = 1'h1;
    wait_cyc(HALF);
  endtask
  // clock lowered; data released shows the inverse so a stale sample cannot pass
  task automatic fall_bit;
    ser_clk = 1'h0;
    ser_din = ~ser_din;
    wait_cyc(HALF / 2);
  endtask
  // one full link period per bit
  task automatic shift_bit(input logic b);
    rise_bit(b);
    fall_bit();
  endtask
  task automatic send_word(input logic [11:0] w);
    for (int i = 11; i >= 0; i--) begin
      shift_bit(w[i]);
    end
  endtask
  // load level, held one half period before anything else moves
  task automatic set_load(input logic v);
    ser_load = v;
    wait_cyc(HALF);
  endtask
endmodule

// ===== bench/ssld_top_tb.sv
// ----------------------------------------------------------------
// testbench for the serial shift latch driver
// ----------------------------------------------------------------
module ssld_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and pins
  logic CLOCK = 1'h0;
  logic RST_N = 1'h0;
  logic SER_CLK, SER_DIN, SER_LOAD, SER_DOUT, SHUTDOWN;
  logic SER_BLANK = 1'h0;
  logic [11:0] DRIVER_OUTPUTS;
  // bookkeeping; ceiling well above the roughly 1450 cycles needed
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  ssld_top ssld_top_i (
    .CLOCK(CLOCK),
    .RST_N(RST_N),
    .SER_CLK(SER_CLK),
    .SER_DIN(SER_DIN),
    .SER_LOAD(SER_LOAD),
    .SER_BLANK(SER_BLANK),
    .SER_DOUT(SER_DOUT),
    .DRIVER_OUTPUTS(DRIVER_OUTPUTS),
    .SHUTDOWN(SHUTDOWN)
  );
  ssld_ctl_model ssld_ctl_model_i (
    .clk(CLOCK),
    .ser_clk(SER_CLK),
    .ser_din(SER_DIN),
    .ser_load(SER_LOAD)
  );
  // 8 ns clock
  initial begin
    forever #4 CLOCK = ~CLOCK;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // word shifted in and strobed, cascade bit follows last stage
  task automatic t_load;
    ssld_ctl_model_i.send_word(12'ha5c);
    ssld_ctl_model_i.set_load(1'h1);
    ssld_ctl_model_i.set_load(1'h0);
    chk("outputs", 12'ha5c, DRIVER_OUTPUTS);
    chk("dout", 12'h001, {11'h000, SER_DOUT});
  endtask
  // shifting with load low leaves the latch alone; last 12 bits win
  task automatic t_hold;
    ssld_ctl_model_i.send_word(12'h3c9);
    tick(8);
    chk("held", 12'ha5c, DRIVER_OUTPUTS);
    chk("dout", 12'h000, {11'h000, SER_DOUT});
    ssld_ctl_model_i.shift_bit(1'h1);
    chk("dout", 12'h000, {11'h000, SER_DOUT});
    // serial clock still high here: the cascade bit must already have moved
    ssld_ctl_model_i.rise_bit(1'h1);
    chk("dout at rise", 12'h001, {11'h000, SER_DOUT});
    ssld_ctl_model_i.fall_bit();
    ssld_ctl_model_i.set_load(1'h1);
    ssld_ctl_model_i.set_load(1'h0);
    chk("last twelve", 12'hf27, DRIVER_OUTPUTS);
  endtask
  // reset in mid-run clears outputs, cascade bit and the stored word
  task automatic t_reset;
    ssld_ctl_model_i.shift_bit(1'h1);
    chk("dout", 12'h001, {11'h000, SER_DOUT});
    RST_N = 1'h0;
    tick(2);
    chk("reset outputs", 12'h000, DRIVER_OUTPUTS);
    chk("reset dout", 12'h000, {11'h000, SER_DOUT});
    RST_N = 1'h1;
    tick(6);
    ssld_ctl_model_i.set_load(1'h1);
    ssld_ctl_model_i.set_load(1'h0);
    chk("cleared word", 12'h000, DRIVER_OUTPUTS);
  endtask
  // load held high: outputs follow the shift register
  task automatic t_trans;
    ssld_ctl_model_i.set_load(1'h1);
    ssld_ctl_model_i.send_word(12'h0f1);
    tick(8);
    chk("follow", 12'h0f1, DRIVER_OUTPUTS);
    ssld_ctl_model_i.set_load(1'h0);
    ssld_ctl_model_i.send_word(12'hfff);
    tick(8);
    chk("captured", 12'h0f1, DRIVER_OUTPUTS);
  endtask
  // blanking forces low, shifting and latching carry on beneath it
  task automatic t_blank;
    SER_BLANK = 1'h1;
    tick(8);
    chk("blanked", 12'h000, DRIVER_OUTPUTS);
    chk("shutdown", 12'h001, {11'h000, SHUTDOWN});
    ssld_ctl_model_i.send_word(12'h5a3);
    ssld_ctl_model_i.set_load(1'h1);
    ssld_ctl_model_i.set_load(1'h0);
    chk("blanked", 12'h000, DRIVER_OUTPUTS);
    SER_BLANK = 1'h0;
    tick(8);
    chk("unblanked", 12'h5a3, DRIVER_OUTPUTS);
    chk("shutdown", 12'h000, {11'h000, SHUTDOWN});
  endtask
  // main sequence
  initial begin
    tick(20);
    chk("reset outputs", 12'h000, DRIVER_OUTPUTS);
    chk("reset dout", 12'h000, {11'h000, SER_DOUT});
    RST_N = 1'h1;
    tick(6);
    t_load();
    t_hold();
    t_trans();
    t_blank();
    t_reset();
    end_of_test();
  end
endmodule

// ===== pkg/ssld_map.svh
`ifndef SSLD_MAP_SVH
`define SSLD_MAP_SVH
// Behaviour
// - rising serial clock shifts input into register
// - one word is twelve bits, one per output
// - twelve outputs, each from its latch bit
// - load high makes latch follow shift register
// - load falling edge captures shift register contents
// - load low holds latch despite shifting
// - blank high forces outputs low, latch kept
// - blank low shows latch bits on outputs
// - blank high also signals shutdown mode
// - reset clears register, latch, outputs, serial out
// - last stage drives serial data output
// - serial output updates on rising clock edge
// - blanking independent of shifting and latching

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define SSLD_WORD_BITS 12
`define SSLD_WORD_RST 12'h000
`define SSLD_BIT_RST 1'h0
`define SSLD_SYNC_RST 2'h0
`endif

// ===== pkg/ssld_pkg.sv
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package ssld_pkg;
  // operating mode shown on the shutdown output
  typedef enum logic {SSLD_RUN, SSLD_SHUTDOWN} ssld_mode_t;
endpackage

// ===== src/ssld_sync.sv
`include "ssld_map.svh"
// ----------------------------------------------------------------
// two flop synchroniser, one per bit
// ----------------------------------------------------------------
module ssld_sync
  import ssld_pkg::*;
#(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous inputs and synchronised copy
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  genvar i;
  // each bit crosses on its own; first stage only feeds the second
  for (i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_ff; // first stage, read by second only
    logic hold_ff; // second stage
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta_ff <= `SSLD_BIT_RST;
        hold_ff <= `SSLD_BIT_RST;
      end else begin
        meta_ff <= d[i];
        hold_ff <= meta_ff;
      end
    end
    assign q[i] = hold_ff;
  end
endmodule

// ===== src/ssld_top.sv
`include "ssld_map.svh"
// ----------------------------------------------------------------
// serial shift latch driver, oversampled on CLOCK
// ----------------------------------------------------------------
module ssld_top
  import ssld_pkg::*;
#(
  parameter int WORD_BITS = `SSLD_WORD_BITS
) (
  // system clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // serial interface pins
  input wire logic SER_CLK,
  input wire logic SER_DIN,
  input wire logic SER_LOAD,
  input wire logic SER_BLANK,
  output logic SER_DOUT,
  // display drive
  output logic [WORD_BITS-1:0] DRIVER_OUTPUTS,
  output logic SHUTDOWN
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_ff; // release shifter
  logic rst_n; // synchronised reset
  // reset release
  // asserts at once, releases two clocks later, so no flop leaves reset
  // on an edge that another one still misses
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= `SSLD_SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [3:0] pins_s; // {blank, load, din, clk}
  ssld_sync #(.WIDTH(4)) u_sync (
    .clk(CLOCK),
    .rst_n(rst_n),
    .d({SER_BLANK, SER_LOAD, SER_DIN, SER_CLK}),
    .q(pins_s)
  );
  logic sclk_s, din_s, load_s, blank_s;
  assign sclk_s = pins_s[0];
  assign din_s = pins_s[1];
  assign load_s = pins_s[2];
  assign blank_s = pins_s[3];

  // ----------------------------------------------------------------
  // edge detection
  // ----------------------------------------------------------------
  logic sclk_d_ff; // previous serial clock level
  logic load_d_ff; // previous load level
  // both reset low, the idle level of the serial clock: no false rise
  // after reset; a load pin held high at reset only starts following
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_ff <= `SSLD_BIT_RST;
      load_d_ff <= `SSLD_BIT_RST;
    end else begin
      sclk_d_ff <= sclk_s;
      load_d_ff <= load_s;
    end
  end
  logic sclk_rise, load_fall;
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign load_fall = ~load_s & load_d_ff;

  // ----------------------------------------------------------------
  // shift register
  // ----------------------------------------------------------------
  // one stage per word bit
  logic [WORD_BITS-1:0] shift_ff; // twelve stages
  logic [WORD_BITS-1:0] nxt_shift;
  // data settled at the same sampled edge as the clock; using the
  // current copy keeps setup/hold symmetric around the edge
  assign nxt_shift = {shift_ff[WORD_BITS-2:0], din_s};
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= `SSLD_WORD_RST;
    end else if (sclk_rise) begin
      shift_ff <= nxt_shift;
    end
  end

  // ----------------------------------------------------------------
  // output latch
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] latch_ff; // display word
  // transparent latch
  // following while high makes the falling edge keep the last value
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      latch_ff <= `SSLD_WORD_RST;
    end else if (load_s || load_fall) begin
      latch_ff <= shift_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // blanked drive
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      DRIVER_OUTPUTS <= `SSLD_WORD_RST;
    end else if (blank_s) begin
      DRIVER_OUTPUTS <= `SSLD_WORD_RST;
    end else begin
      DRIVER_OUTPUTS <= latch_ff;
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      SHUTDOWN <= `SSLD_BIT_RST;
    end else begin
      SHUTDOWN <= (blank_s ? SSLD_SHUTDOWN : SSLD_RUN);
    end
  end

  // cascade output
  // the last stage after the rising-edge shift, so it moves then
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      SER_DOUT <= `SSLD_BIT_RST;
    end else if (sclk_rise) begin
      SER_DOUT <= shift_ff[WORD_BITS-2];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_shift;
    @(posedge CLOCK) disable iff (!rst_n)
      sclk_rise |=> shift_ff == {$past(shift_ff[WORD_BITS-2:0]), $past(din_s)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift wrong");
  property p_hold_shift;
    @(posedge CLOCK) disable iff (!rst_n) !sclk_rise |=> $stable(shift_ff);
  endproperty
  a_hold_shift: assert property (p_hold_shift) else $error("shift moved");
  property p_transp;
    @(posedge CLOCK) disable iff (!rst_n) load_s |=> latch_ff == $past(shift_ff);
  endproperty
  a_transp: assert property (p_transp) else $error("latch not following");
  sequence s_load_drop;
    load_d_ff ##0 !load_s;
  endsequence
  property p_capture;
    @(posedge CLOCK) disable iff (!rst_n) s_load_drop |=> latch_ff == $past(shift_ff);
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed");
  property p_latch_hold;
    @(posedge CLOCK) disable iff (!rst_n) (!load_s && !load_d_ff) |=> $stable(latch_ff);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed");
  property p_blank;
    @(posedge CLOCK) disable iff (!rst_n) blank_s |=> DRIVER_OUTPUTS == '0;
  endproperty
  a_blank: assert property (p_blank) else $error("outputs not blanked");
  property p_show;
    @(posedge CLOCK) disable iff (!rst_n) !blank_s |=> DRIVER_OUTPUTS == $past(latch_ff);
  endproperty
  a_show: assert property (p_show) else $error("outputs not latch");
  property p_shutdown;
    @(posedge CLOCK) disable iff (!rst_n) ##1 SHUTDOWN == $past(blank_s);
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown wrong");
  property p_dout;
    @(posedge CLOCK) disable iff (!rst_n) sclk_rise |=> SER_DOUT == shift_ff[WORD_BITS-1];
  endproperty
  a_dout: assert property (p_dout) else $error("dout not last stage");

  // ----------------------------------------------------------------
  // reset, cascade and blanking assertions
  // ----------------------------------------------------------------
  // pins that the display and the next driver see, all at zero
  sequence s_pins_clear;
    DRIVER_OUTPUTS == '0 ##0 !SER_DOUT ##0 !SHUTDOWN;
  endsequence
  // internal storage, cleared so a stale word cannot be loaded later
  sequence s_store_clear;
    shift_ff == '0 ##0 latch_ff == '0;
  endsequence
  // no disable here: this one is only meant to look inside reset
  property p_reset_clear;
    @(posedge CLOCK) !rst_n |-> s_pins_clear ##0 s_store_clear;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");
  // the cascade bit moves with a serial clock rise and at no other time
  property p_dout_edge;
    @(posedge CLOCK) disable iff (!rst_n) !sclk_rise |=> $stable(SER_DOUT);
  endproperty
  a_dout_edge: assert property (p_dout_edge) else $error("dout moved off edge");
  // the cascade pin always mirrors the last stage, never lags behind it
  property p_dout_mirror;
    @(posedge CLOCK) disable iff (!rst_n) SER_DOUT == shift_ff[WORD_BITS-1];
  endproperty
  a_dout_mirror: assert property (p_dout_mirror) else $error("dout not mirroring");
  // a blank change while the latch holds must leave the latch alone
  sequence s_blank_move;
    !load_s && !load_d_ff && $changed(blank_s);
  endsequence
  property p_blank_keeps;
    @(posedge CLOCK) disable iff (!rst_n) s_blank_move |=> $stable(latch_ff);
  endproperty
  a_blank_keeps: assert property (p_blank_keeps) else $error("blank moved latch");
  // shifting goes on under blanking: a rise while blanked still fills stage zero
  property p_blank_shift;
    @(posedge CLOCK) disable iff (!rst_n)
      (blank_s && sclk_rise) |=> shift_ff[0] == $past(din_s);
  endproperty
  a_blank_shift: assert property (p_blank_shift) else $error("blank stalled shift");
endmodule
